// *** src/ecv_pkg.sv ***
package ecv_pkg;

  // Vector offsets of the four exception classes
  localparam logic [19:0] VEC_EXTERNAL   = 20'h00500;
  localparam logic [19:0] VEC_ALIGN      = 20'h00600;
  localparam logic [19:0] VEC_PROGRAM    = 20'h00700;
  localparam logic [19:0] VEC_FP_UNAVAIL = 20'h00800;
  localparam logic [19:0] VEC_NONE       = 20'h00000;

  // Register byte addresses
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_FSTAT  = 4'h4;
  localparam logic [3:0]  ADDR_STATUS = 4'h8;
  localparam logic [3:0]  ADDR_FETCH  = 4'hc;

  // Control register: machine_state_reg bits plus cache state and base prefix
  localparam int          CTRL_USER       = 0;
  localparam int          CTRL_FAVAIL     = 1;
  localparam int          CTRL_MODE_A     = 2;
  localparam int          CTRL_MODE_B     = 3;
  localparam int          CTRL_MCE        = 4;
  localparam int          CTRL_DC_LOCK    = 5;
  localparam int          CTRL_DC_OFF     = 6;
  localparam int          CTRL_PREFIX_LSB = 20;
  localparam int          PREFIX_W        = 12;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK      = 32'hfff0_007f;

  // float_status_ctrl_reg: enables, conditions, summary
  localparam int          FSTAT_EN_LSB   = 0;
  localparam int          FSTAT_COND_LSB = 8;
  localparam int          FSTAT_FLD_W    = 5;
  localparam int          FSTAT_SUM      = 31;
  localparam logic [31:0] FSTAT_RESET    = 32'h0000_0000;
  localparam logic [31:0] FSTAT_WMASK    = 32'h8000_1f1f;

  // Status register fields
  localparam int          ST_CAUSE_LSB = 0;
  localparam int          ST_INT_PEND  = 8;
  localparam int          ST_HOLD      = 9;
  localparam int          ST_VEC_LSB   = 12;

  // Cause bits of save_restore_reg_one
  localparam int          CAUSE_W       = 4;
  localparam int          CAUSE_TRAP    = 0;
  localparam int          CAUSE_PRIV    = 1;
  localparam int          CAUSE_ILLEGAL = 2;
  localparam int          CAUSE_FP      = 3;

  // External interrupt sequencing, Gray coded
  typedef enum logic [1:0] {
    ECV_IDLE    = 2'b00,
    ECV_DRAIN   = 2'b01,
    ECV_RELEASE = 2'b11
  } ecv_state_type;

endpackage : ecv_pkg

// *** src/ecv_cause_if.sv ***
interface ecv_cause_if;
  logic       valid;
  logic       is_fp;
  logic       fp_mem;
  logic       word_access;
  logic       cache_zero;
  logic       ext_ctrl;
  logic       illegal_op;
  logic       opt_missing;
  logic       opt_nop;
  logic       privileged;
  logic       spr_move;
  logic       spr_invalid;
  logic       spr_bit0;
  logic       trap;
  logic [4:0] trap_sel;
  logic [4:0] trap_cmp;
  logic [1:0] ea_low;
  logic       page_ci;
  logic       page_wt;
  logic       user_priv;
  logic       float_avail;
  logic       dc_locked;
  logic       dc_off;
  logic       align_exc;
  logic       illegal_exc;
  logic       priv_exc;
  logic       trap_exc;
  logic       fpu_exc;

  modport core (
    output valid, is_fp, fp_mem, word_access, cache_zero, ext_ctrl, illegal_op, opt_missing, opt_nop,
    output privileged, spr_move, spr_invalid, spr_bit0, trap, trap_sel, trap_cmp, ea_low, page_ci, page_wt,
    output user_priv, float_avail, dc_locked, dc_off,
    input  align_exc, illegal_exc, priv_exc, trap_exc, fpu_exc
  );
  modport decoder (
    input  valid, is_fp, fp_mem, word_access, cache_zero, ext_ctrl, illegal_op, opt_missing, opt_nop,
    input  privileged, spr_move, spr_invalid, spr_bit0, trap, trap_sel, trap_cmp, ea_low, page_ci, page_wt,
    input  user_priv, float_avail, dc_locked, dc_off,
    output align_exc, illegal_exc, priv_exc, trap_exc, fpu_exc
  );
endinterface : ecv_cause_if

// *** src/ecv_cause_decode.sv ***
module ecv_cause_decode (
  ecv_cause_if.decoder cif
);

  logic misaligned;

  // Word alignment of the effective address
  assign misaligned = |cif.ea_low;

  // Alignment causes
  assign cif.align_exc = cif.valid &
                         (((cif.fp_mem | cif.word_access) & misaligned) |            // [RULE5]
                          (cif.cache_zero & (cif.page_ci | cif.page_wt)) |            // [RULE6]
                          (cif.cache_zero & (cif.dc_locked | cif.dc_off)) |           // [RULE7]
                          (cif.ext_ctrl & misaligned));                               // [RULE8]

  // Illegal opcode, skipping optional no-ops
  assign cif.illegal_exc = cif.valid & (cif.illegal_op | cif.opt_missing) & ~cif.opt_nop; // [RULE12]

  // Privileged use in user state, also bad special register moves
  assign cif.priv_exc = cif.valid & cif.user_priv &
                        (cif.privileged |                                             // [RULE13]
                         (cif.spr_move & cif.spr_invalid & cif.spr_bit0));            // [RULE14]

  // Trap when any selected compare is true
  assign cif.trap_exc = cif.valid & cif.trap & (|(cif.trap_sel & cif.trap_cmp));      // [RULE15]

  // Floating-point work while the unit is unavailable
  assign cif.fpu_exc = cif.valid & (cif.is_fp | cif.fp_mem) & ~cif.float_avail;      // [RULE16]

endmodule : ecv_cause_decode

// *** src/ecv_top.sv ***
// What this block does
// RULE1 - Asserted low external request is taken at vector 0x00500.
// RULE2 - The source keeps the request asserted until the handler starts.
// RULE3 - On request, stop dispatch and wait for dispatched work to complete.
// RULE4 - Exceptions of already dispatched instructions go before the external one.
// RULE5 - Misaligned float, multiple word, reserve or conditional access gives alignment, 0x00600.
// RULE6 - Cache block zero to inhibited or write-through page gives alignment.
// RULE7 - Cache block zero with data cache locked or off gives alignment.
// RULE8 - Misaligned external control word access gives alignment.
// RULE9 - Program exceptions go to 0x00700 with cause bits saved.
// RULE10 - Float enabled program exception follows summary bit and the two mode bits.
// RULE11 - Summary bit set by enabled float fault or status write with condition and enable.
// RULE12 - Illegal or missing optional opcode gives illegal program exception, no-ops excepted.
// RULE13 - Privileged instruction in user state gives privileged program exception.
// RULE14 - Invalid special register move with field bit 0 in user state is privileged too.
// RULE15 - Trap instruction with any selected compare true gives trap program exception.
// RULE16 - Float instruction with float unit unavailable goes to 0x00800.
// RULE17 - Taking any exception clears machine check enable.
// RULE18 - Handler fetch address is base prefix joined with vector offset.
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
module ecv_top (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  input  wire logic        INT_REQ_N,
  input  wire logic        INFLIGHT_EMPTY,
  input  wire logic        INSN_VALID,
  input  wire logic        INSN_IS_FP,
  input  wire logic        INSN_FP_MEM,
  input  wire logic        INSN_WORD_ACCESS,
  input  wire logic        INSN_CACHE_ZERO,
  input  wire logic        INSN_EXT_CTRL,
  input  wire logic        INSN_ILLEGAL_OP,
  input  wire logic        INSN_OPT_MISSING,
  input  wire logic        INSN_OPT_NOP,
  input  wire logic        INSN_PRIVILEGED,
  input  wire logic        INSN_SPR_MOVE,
  input  wire logic        INSN_SPR_INVALID,
  input  wire logic        INSN_SPR_BIT0,
  input  wire logic        INSN_TRAP,
  input  wire logic [4:0]  TRAP_SELECT,
  input  wire logic [4:0]  TRAP_COMPARE,
  input  wire logic [1:0]  INSN_EA_LOW,
  input  wire logic        PAGE_CACHE_INHIBIT,
  input  wire logic        PAGE_WRITE_THROUGH,
  input  wire logic        INSN_FP_ENABLED_EXC,
  output logic             DISPATCH_HOLD,
  output logic             EXC_TAKEN,
  output logic      [19:0] EXC_VECTOR,
  output logic      [31:0] FETCH_ADDR,
  output logic      [3:0]  SAVE_RESTORE_REG_ONE
);

  ecv_cause_if cif ();

  ecv_pkg::ecv_state_type    state_reg;
  ecv_pkg::ecv_state_type    state_next;
  logic                      int_meta_reg;
  logic                      int_sync_reg;
  logic                      int_req;
  logic [31:0]               ctrl_reg;
  logic [31:0]               fstat_reg;
  logic [31:0]               fstat_merge;
  logic                      armed;
  logic                      armed_prev_reg;
  logic                      fp_pend_reg;
  logic                      insn_exc;
  logic                      ext_take;
  logic                      take;
  logic [19:0]               vec_next;
  logic [3:0]                cause_next;
  logic                      bus_req;
  logic                      bus_wr;
  logic                      waitreq_reg;
  logic [31:0]               rdata_reg;
  logic                      taken_reg;
  logic [19:0]               vector_reg;
  logic [31:0]               fetch_reg;
  logic [3:0]                cause_reg;
  logic                      hold_reg;

  // Merge of write data under byte enables, limited to writable bits
  function automatic logic [31:0] be_merge(input logic [31:0] old_val, input logic [31:0] new_val,
                                           input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      for (int b = 0; b < 8; b++) begin
        if (be[i] && wmask[i*8+b]) begin
          res[i*8+b] = new_val[i*8+b];
        end
      end
    end
    return res;
  endfunction : be_merge

  ////////////////////////////////////////////////////////////////////////////
  // Cause decoding

  assign cif.valid       = INSN_VALID;
  assign cif.is_fp       = INSN_IS_FP;
  assign cif.fp_mem      = INSN_FP_MEM;
  assign cif.word_access = INSN_WORD_ACCESS;
  assign cif.cache_zero  = INSN_CACHE_ZERO;
  assign cif.ext_ctrl    = INSN_EXT_CTRL;
  assign cif.illegal_op  = INSN_ILLEGAL_OP;
  assign cif.opt_missing = INSN_OPT_MISSING;
  assign cif.opt_nop     = INSN_OPT_NOP;
  assign cif.privileged  = INSN_PRIVILEGED;
  assign cif.spr_move    = INSN_SPR_MOVE;
  assign cif.spr_invalid = INSN_SPR_INVALID;
  assign cif.spr_bit0    = INSN_SPR_BIT0;
  assign cif.trap        = INSN_TRAP;
  assign cif.trap_sel    = TRAP_SELECT;
  assign cif.trap_cmp    = TRAP_COMPARE;
  assign cif.ea_low      = INSN_EA_LOW;
  assign cif.page_ci     = PAGE_CACHE_INHIBIT;
  assign cif.page_wt     = PAGE_WRITE_THROUGH;
  assign cif.user_priv   = ctrl_reg[ecv_pkg::CTRL_USER];
  assign cif.float_avail = ctrl_reg[ecv_pkg::CTRL_FAVAIL];
  assign cif.dc_locked   = ctrl_reg[ecv_pkg::CTRL_DC_LOCK];
  assign cif.dc_off      = ctrl_reg[ecv_pkg::CTRL_DC_OFF];

  ecv_cause_decode u_decode (
    .cif (cif.decoder)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pin synchroniser

  // Two flops before any logic looks at the pin
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      int_meta_reg <= 1'b1;
      int_sync_reg <= 1'b1;
    end else begin
      int_meta_reg <= INT_REQ_N;
      int_sync_reg <= int_meta_reg;
    end
  end

  assign int_req = ~int_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Exception selection

  // Float enabled condition armed by summary and either mode bit
  assign armed = fstat_reg[ecv_pkg::FSTAT_SUM] &
                 (ctrl_reg[ecv_pkg::CTRL_MODE_A] | ctrl_reg[ecv_pkg::CTRL_MODE_B]); // [RULE10]

  assign insn_exc = cif.align_exc | cif.illegal_exc | cif.priv_exc | cif.trap_exc | cif.fpu_exc | fp_pend_reg;

  // External one only once drained and nothing older is pending
  assign ext_take = (state_reg == ecv_pkg::ECV_DRAIN) && INFLIGHT_EMPTY && !insn_exc; // [RULE3] [RULE4]
  assign take     = insn_exc | ext_take;

  // Priority: illegal or privileged, unavailable, alignment, trap or float enabled
  always_comb begin
    vec_next   = ecv_pkg::VEC_NONE;
    cause_next = '0;
    if (cif.illegal_exc || cif.priv_exc) begin
      vec_next                            = ecv_pkg::VEC_PROGRAM;            // [RULE9]
      cause_next[ecv_pkg::CAUSE_ILLEGAL]  = cif.illegal_exc;                 // [RULE12]
      cause_next[ecv_pkg::CAUSE_PRIV]     = cif.priv_exc;                    // [RULE13] [RULE14]
    end else if (cif.fpu_exc) begin
      vec_next = ecv_pkg::VEC_FP_UNAVAIL;                                    // [RULE16]
    end else if (cif.align_exc) begin
      vec_next = ecv_pkg::VEC_ALIGN;                                         // [RULE5]
    end else if (cif.trap_exc || fp_pend_reg) begin
      vec_next                        = ecv_pkg::VEC_PROGRAM;                // [RULE9]
      cause_next[ecv_pkg::CAUSE_TRAP] = cif.trap_exc;                        // [RULE15]
      cause_next[ecv_pkg::CAUSE_FP]   = fp_pend_reg;                         // [RULE10]
    end else if (ext_take) begin
      vec_next = ecv_pkg::VEC_EXTERNAL;                                      // [RULE1]
    end
  end

  // Pending float enabled exception, raised on arming, set wins over clear
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      armed_prev_reg <= 1'b0;
      fp_pend_reg    <= 1'b0;
    end else begin
      armed_prev_reg <= armed;
      if (armed && !armed_prev_reg) begin
        fp_pend_reg <= 1'b1;                                                 // [RULE10]
      end else if (cause_next[ecv_pkg::CAUSE_FP]) begin
        fp_pend_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External interrupt sequencing

  // Idle, drain dispatched work, then wait for the source to let go
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ecv_pkg::ECV_IDLE: begin
        if (int_req) begin
          state_next = ecv_pkg::ECV_DRAIN;                                   // [RULE3]
        end
      end
      ecv_pkg::ECV_DRAIN: begin
        if (ext_take) begin
          state_next = ecv_pkg::ECV_RELEASE;
        end
      end
      ecv_pkg::ECV_RELEASE: begin
        if (!int_req) begin
          state_next = ecv_pkg::ECV_IDLE;                                    // [RULE2]
        end
      end
      default: begin
        state_next = ecv_pkg::ECV_IDLE;
      end
    endcase
  end

  // State and dispatch hold
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= ecv_pkg::ECV_IDLE;
      hold_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      hold_reg  <= (state_next == ecv_pkg::ECV_DRAIN);                       // [RULE3]
    end
  end

  // Taken pulse, vector, handler address and saved cause bits
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      taken_reg  <= 1'b0;
      vector_reg <= ecv_pkg::VEC_NONE;
      fetch_reg  <= '0;
      cause_reg  <= '0;
    end else begin
      taken_reg <= take;
      if (take) begin
        vector_reg <= vec_next;
        fetch_reg  <= {ctrl_reg[ecv_pkg::CTRL_PREFIX_LSB +: ecv_pkg::PREFIX_W], vec_next}; // [RULE18]
        cause_reg  <= cause_next;                                            // [RULE9]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave

  assign bus_req = AVS_READ | AVS_WRITE;
  assign bus_wr  = AVS_WRITE && !waitreq_reg;

  // One wait cycle per request, then one cycle low
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      waitreq_reg <= 1'b1;
    end else begin
      waitreq_reg <= !(bus_req && waitreq_reg);
    end
  end

  // Read data captured during the wait cycle
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_reg <= '0;
    end else if (AVS_READ && waitreq_reg) begin
      case (AVS_ADDRESS)
        ecv_pkg::ADDR_CTRL:   rdata_reg <= ctrl_reg;
        ecv_pkg::ADDR_FSTAT:  rdata_reg <= fstat_reg;
        ecv_pkg::ADDR_STATUS: begin
          rdata_reg                                        <= '0;
          rdata_reg[ecv_pkg::ST_CAUSE_LSB +: ecv_pkg::CAUSE_W] <= cause_reg;
          rdata_reg[ecv_pkg::ST_INT_PEND]                  <= int_req;
          rdata_reg[ecv_pkg::ST_HOLD]                      <= hold_reg;
          rdata_reg[ecv_pkg::ST_VEC_LSB +: 20]             <= vector_reg;
        end
        ecv_pkg::ADDR_FETCH:  rdata_reg <= fetch_reg;
        default:              rdata_reg <= '0;
      endcase
    end
  end

  // Control register; taking an exception clears machine check enable
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_reg <= ecv_pkg::CTRL_RESET;
    end else begin
      if (bus_wr && AVS_ADDRESS == ecv_pkg::ADDR_CTRL) begin
        ctrl_reg <= be_merge(ctrl_reg, AVS_WRITEDATA, AVS_BYTEENABLE, ecv_pkg::CTRL_WMASK);
      end
      if (take) begin
        ctrl_reg[ecv_pkg::CTRL_MCE] <= 1'b0;                                 // [RULE17]
      end
    end
  end

  assign fstat_merge = be_merge(fstat_reg, AVS_WRITEDATA, AVS_BYTEENABLE, ecv_pkg::FSTAT_WMASK);

  // Float status; an enabled float fault, or a status write with a condition and its enable, sets the summary
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      fstat_reg <= ecv_pkg::FSTAT_RESET;
    end else begin
      if (bus_wr && AVS_ADDRESS == ecv_pkg::ADDR_FSTAT) begin
        fstat_reg <= fstat_merge;
        fstat_reg[ecv_pkg::FSTAT_SUM] <= fstat_merge[ecv_pkg::FSTAT_SUM] |
          (|(fstat_merge[ecv_pkg::FSTAT_COND_LSB +: ecv_pkg::FSTAT_FLD_W] &
             fstat_merge[ecv_pkg::FSTAT_EN_LSB +: ecv_pkg::FSTAT_FLD_W]));  // [RULE11]
      end
      if (INSN_VALID && INSN_FP_ENABLED_EXC) begin
        fstat_reg[ecv_pkg::FSTAT_SUM] <= 1'b1;                               // [RULE11]
      end
    end
  end

  assign AVS_READDATA         = rdata_reg;
  assign AVS_WAITREQUEST      = waitreq_reg;
  assign DISPATCH_HOLD        = hold_reg;
  assign EXC_TAKEN            = taken_reg;
  assign EXC_VECTOR           = vector_reg;
  assign FETCH_ADDR           = fetch_reg;
  assign SAVE_RESTORE_REG_ONE = cause_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  ext_vector_a: assert property (ext_take |=> EXC_TAKEN && EXC_VECTOR == ecv_pkg::VEC_EXTERNAL) // [RULE1]
    else $error("external interrupt not taken at its vector");
  drain_hold_a: assert property (state_reg == ecv_pkg::ECV_DRAIN |-> DISPATCH_HOLD) // [RULE3]
    else $error("dispatch not held while draining");
  drain_wait_a: assert property ((state_reg == ecv_pkg::ECV_DRAIN && !INFLIGHT_EMPTY)
                                 |=> !(EXC_TAKEN && EXC_VECTOR == ecv_pkg::VEC_EXTERNAL)) // [RULE3]
    else $error("external interrupt taken before drain completed");
  older_first_a: assert property ((state_reg == ecv_pkg::ECV_DRAIN && insn_exc)
                                  |=> EXC_TAKEN && EXC_VECTOR != ecv_pkg::VEC_EXTERNAL
                                      && state_reg == ecv_pkg::ECV_DRAIN) // [RULE4]
    else $error("instruction exception not ahead of external interrupt");
  align_vec_a: assert property ((cif.align_exc && !cif.illegal_exc && !cif.priv_exc && !cif.fpu_exc)
                                |=> EXC_TAKEN && EXC_VECTOR == ecv_pkg::VEC_ALIGN) // [RULE5] [RULE6] [RULE7] [RULE8]
    else $error("alignment exception not taken");
  priv_cause_a: assert property ((cif.priv_exc && !cif.illegal_exc) |=> EXC_VECTOR == ecv_pkg::VEC_PROGRAM
                                 && SAVE_RESTORE_REG_ONE[ecv_pkg::CAUSE_PRIV]) // [RULE9] [RULE13]
    else $error("privileged cause not recorded");
  trap_cause_a: assert property ((cif.trap_exc && !cif.illegal_exc && !cif.priv_exc && !cif.fpu_exc && !cif.align_exc)
                                 |=> SAVE_RESTORE_REG_ONE[ecv_pkg::CAUSE_TRAP]) // [RULE15]
    else $error("trap cause not recorded");
  fpu_vec_a: assert property ((INSN_VALID && INSN_IS_FP && !ctrl_reg[ecv_pkg::CTRL_FAVAIL]
                               && !cif.illegal_exc && !cif.priv_exc) |=> EXC_VECTOR == ecv_pkg::VEC_FP_UNAVAIL) // [RULE16]
    else $error("float unavailable not taken");
  fp_arm_a: assert property ((armed && !armed_prev_reg) |=> fp_pend_reg) // [RULE10]
    else $error("float enabled exception not pended");
  fsum_set_a: assert property ((INSN_VALID && INSN_FP_ENABLED_EXC) |=> fstat_reg[ecv_pkg::FSTAT_SUM]) // [RULE11]
    else $error("summary bit not set");
  mce_clear_a: assert property (EXC_TAKEN |-> !ctrl_reg[ecv_pkg::CTRL_MCE]) // [RULE17]
    else $error("machine check enable left set");
  fetch_addr_a: assert property (EXC_TAKEN |-> FETCH_ADDR == {$past(ctrl_reg[31:20]), EXC_VECTOR}) // [RULE18]
    else $error("handler address mismatch");

  ext_taken_c: cover property (ext_take ##1 EXC_TAKEN);
  align_taken_c: cover property (cif.align_exc ##1 EXC_VECTOR == ecv_pkg::VEC_ALIGN);
  fp_taken_c: cover property (fp_pend_reg ##1 SAVE_RESTORE_REG_ONE[ecv_pkg::CAUSE_FP]);
  drain_exc_c: cover property (state_reg == ecv_pkg::ECV_DRAIN && insn_exc);

endmodule : ecv_top

// *** tb/ecv_irq_source.sv ***
module ecv_irq_source (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic raise,
  input  wire logic handler_go,
  output logic      int_req_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // Request held low until the handler starts, idle high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) int_req_n <= 1'b1;
    else if (handler_go) int_req_n <= 1'b1;
    else if (raise) int_req_n <= 1'b0;
  end
endmodule : ecv_irq_source

// *** tb/ecv_top_tb.sv ***
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin failures++; $display("Error %s exp %h got %h", n, e, a); end end
module ecv_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst = 1, rd = 0, wr = 0, vld = 0, empty = 1, raise = 0, int_n;
  logic [3:0]  adr = 0;
  logic [31:0] wdat = 0, q;
  // Class bits [13:0], low address [15:14], page [17:16], select [22:18], compare [27:23]
  logic [27:0] f = 0;
  int          failures = 0, checks_done = 0, cyc = 0;
  wire  [31:0] rdat, fetch;
  wire  [19:0] vec;
  wire  [3:0]  cause;
  wire         wreq, hold, taken;
  ecv_top i_ecv_top (.CLK(clk), .SYS_RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
    .INT_REQ_N(int_n), .INFLIGHT_EMPTY(empty), .INSN_VALID(vld), .INSN_IS_FP(f[0]), .INSN_FP_MEM(f[1]),
    .INSN_WORD_ACCESS(f[2]), .INSN_CACHE_ZERO(f[3]), .INSN_EXT_CTRL(f[4]), .INSN_ILLEGAL_OP(f[5]),
    .INSN_OPT_MISSING(f[6]), .INSN_OPT_NOP(f[7]), .INSN_PRIVILEGED(f[8]), .INSN_SPR_MOVE(f[9]),
    .INSN_SPR_INVALID(f[10]), .INSN_SPR_BIT0(f[11]), .INSN_TRAP(f[12]), .INSN_FP_ENABLED_EXC(f[13]),
    .INSN_EA_LOW(f[15:14]), .PAGE_CACHE_INHIBIT(f[16]), .PAGE_WRITE_THROUGH(f[17]), .TRAP_SELECT(f[22:18]),
    .TRAP_COMPARE(f[27:23]), .DISPATCH_HOLD(hold), .EXC_TAKEN(taken), .EXC_VECTOR(vec), .FETCH_ADDR(fetch),
    .SAVE_RESTORE_REG_ONE(cause));
  ecv_irq_source i_ecv_irq_source (.clk(clk), .rst(rst), .raise(raise),
    .handler_go(taken & (vec === ecv_pkg::VEC_EXTERNAL)), .int_req_n(int_n));
  always #20 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      print_verdict();
    end
  end
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {wr, rd, adr, wdat} <= {w, !w, a, d};
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    {wr, rd} <= 2'b00;
  endtask : bus
  // One completing instruction, outcome one cycle later
  task automatic insn(input logic [27:0] fl, input logic [24:0] e);
    @(posedge clk);
    {vld, f} <= {1'b1, fl};
    @(posedge clk);
    {vld, f} <= '0;
    #1 `CHK("exception", e, {taken, vec, cause})
  endtask : insn
  task automatic wait_exc(input logic [24:0] e);
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      #1;
      if (taken === 1'b1) begin
        break;
      end
    end
    `CHK("exception", e, {taken, vec, cause})
  endtask : wait_exc
  task automatic t_align();
    bus(1, ecv_pkg::ADDR_CTRL, 32'h0ab0_0013);
    insn(28'h0008002, 25'h1_00600_0);
    `CHK("fetch", 32'h0ab0_0600, fetch)
    bus(0, ecv_pkg::ADDR_CTRL, 0);
    `CHK("ctrl", 32'h0ab0_0003, q)
    insn(28'h0000002, 25'h0_00600_0);
    insn(28'h0004004, 25'h1_00600_0);
    insn(28'h0010008, 25'h1_00600_0);
    insn(28'h0020008, 25'h1_00600_0);
    insn(28'h000c010, 25'h1_00600_0);
    bus(1, ecv_pkg::ADDR_CTRL, 32'h0ab0_0023);
    insn(28'h0000008, 25'h1_00600_0);
    $display("Test align done");
  endtask : t_align
  task automatic t_prog();
    bus(1, ecv_pkg::ADDR_CTRL, 32'h0ab0_0003);
    insn(28'h0000020, 25'h1_00700_4);
    insn(28'h0000040, 25'h1_00700_4);
    insn(28'h0000080, 25'h0_00700_4);
    insn(28'h0000100, 25'h1_00700_2);
    insn(28'h0000e00, 25'h1_00700_2);
    insn(28'h0841000, 25'h1_00700_1);
    insn(28'h1041000, 25'h0_00700_1);
    bus(1, ecv_pkg::ADDR_CTRL, 32'h0ab0_0002);
    insn(28'h0000100, 25'h0_00700_1);
    $display("Test program done");
  endtask : t_prog
  task automatic t_fpu();
    bus(1, ecv_pkg::ADDR_CTRL, 32'h0ab0_0000);
    insn(28'h0000001, 25'h1_00800_0);
    insn(28'h0000002, 25'h1_00800_0);
    bus(1, ecv_pkg::ADDR_CTRL, 32'h0ab0_0006);
    bus(1, ecv_pkg::ADDR_FSTAT, 32'h0000_0101);
    wait_exc(25'h1_00700_8);
    bus(0, ecv_pkg::ADDR_FSTAT, 0);
    `CHK("fstat", 32'h8000_0101, q)
    $display("Test float done");
  endtask : t_fpu
  task automatic t_ext();
    @(posedge clk);
    {empty, raise} <= 2'b01;
    @(posedge clk);
    raise <= 1'b0;
    for (int i = 0; i < 8 && hold !== 1'b1; i++) @(posedge clk);
    `CHK("hold", 1'b1, hold)
    insn(28'h0008002, 25'h1_00600_0);
    @(posedge clk);
    empty <= 1'b1;
    wait_exc(25'h1_00500_0);
    `CHK("hold", 1'b0, hold)
    $display("Test external done");
  endtask : t_ext
  task automatic print_verdict();
    $display("Checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_align();
    t_prog();
    t_fpu();
    t_ext();
    print_verdict();
  end
endmodule : ecv_top_tb
